// ---- ost_defines.svh ----
`ifndef OST_DEFINES_SVH
`define OST_DEFINES_SVH
// Clock and time base
`define OST_CLK_NS      40
`define OST_TICK_NS     1000000
`define OST_CYC_PER_MS  (`OST_TICK_NS / `OST_CLK_NS)
// Register offsets
`define OST_CTRL_OFS    8'h00
`define OST_TIM_BASE    8'h04
`define OST_TIM_LAST    8'h18
`define OST_STAT_OFS    8'h1C
// Control fields
`define OST_CTRL_EN     0
`define OST_CTRL_MODE   1
`define OST_CTRL_TRIP   2
// Status fields
`define OST_ST_LAT1     0
`define OST_ST_LAT2     1
`define OST_ST_LAT3     2
`define OST_ST_LAT4     3
`define OST_ST_BLOCK    4
`define OST_ST_TRIP     5
// Timer indices
`define OST_T_PKP1      0
`define OST_T_RST1      1
`define OST_T_PKP2      2
`define OST_T_PKP3      3
`define OST_T_PKP4      4
`define OST_T_SEAL      5
`define OST_NTIM        6
// Timer reset values in ms
`define OST_PKP1_RST    16'h001E
`define OST_RST1_RST    16'h0032
`define OST_PKP2_RST    16'h0011
`define OST_PKP3_RST    16'h0009
`define OST_PKP4_RST    16'h0011
`define OST_SEAL_RST    16'h0190
`define OST_MS_MAX      16'hFFFF
`endif

// ---- ost_pkg.sv ----
package ost_pkg;
  typedef logic [31:0] ost_word_t;
  typedef logic [15:0] ost_ms_t;
  typedef enum logic {
    OST_TWO   = 1'b0,
    OST_THREE = 1'b1
  } ost_steps_t;
  typedef enum logic {
    OST_DELAYED = 1'b0,
    OST_EARLY   = 1'b1
  } ost_trip_t;
endpackage

// ---- ost_timer.sv ----
`include "ost_defines.svh"
module ost_timer (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           clk_en,
  // Timing
  input  wire logic           tick,
  input  wire logic           run,
  input  wire ost_pkg::ost_ms_t preset,
  output logic                done
);
  import ost_pkg::*;

  ost_ms_t cnt_r;

  // Millisecond count, cleared whenever the timer is not running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_r <= '0;
      end else if (tick && cnt_r != `OST_MS_MAX) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  assign done = run && (cnt_r >= preset);
endmodule

// ---- ost_sequencer.sv ----
`include "ost_defines.svh"
module ost_sequencer #(
  parameter int unsigned CYC_PER_MS = `OST_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire ost_pkg::ost_word_t pwdata,
  output ost_pkg::ost_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Zone and supervision flags
  input  wire logic              zone_outer,
  input  wire logic              zone_middle,
  input  wire logic              zone_inner,
  input  wire logic              overcurrent_supervision,
  input  wire logic              trip_inhibit_input,
  // Element outputs
  output logic                   block_out,
  output logic                   trip_out
);
  import ost_pkg::*;

  localparam int unsigned TCW = $clog2(CYC_PER_MS + 1);
  localparam int NT = `OST_NTIM;
  localparam ost_ms_t PRESET_RST [NT] = '{`OST_PKP1_RST, `OST_RST1_RST,
    `OST_PKP2_RST, `OST_PKP3_RST, `OST_PKP4_RST, `OST_SEAL_RST};

  logic [TCW-1:0] tick_cnt_r;
  logic           tick;
  logic           en_r;
  ost_steps_t     mode_r;
  ost_trip_t      trip_mode_r;
  ost_ms_t        preset_r [NT];
  logic [NT-1:0]  t_run;
  logic [NT-1:0]  t_done;
  logic           lat1_r;
  logic           lat2_r;
  logic           lat3_r;
  logic           lat4_r;
  logic           trip_r;
  logic           three;
  logic           sup;
  logic           in_out;
  logic           in_mid;
  logic           in_inn;
  logic           step1;
  logic           early_pulse;
  logic           late_pulse;
  logic           trip_set;
  logic           aligned;
  logic           ctrl_hit;
  logic           tim_hit;
  logic           stat_hit;
  logic [2:0]     tim_idx;
  logic           wr;
  logic           rd_setup;
  ost_word_t      rdata_nxt;

  // Millisecond tick
  assign tick = (tick_cnt_r == TCW'(CYC_PER_MS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (clk_en) begin
      if (tick) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // Address decode
  assign aligned  = (paddr[1:0] == 2'b00);
  assign ctrl_hit = (paddr == `OST_CTRL_OFS);
  assign stat_hit = (paddr == `OST_STAT_OFS);
  assign tim_hit  = aligned && paddr >= `OST_TIM_BASE && paddr <= `OST_TIM_LAST;
  assign tim_idx  = 3'(paddr[4:2] - 3'd1);
  assign wr       = clk_en && psel && penable && pwrite;
  assign rd_setup = clk_en && psel && !penable;
  assign pready   = clk_en;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r        <= 1'b0;
      mode_r      <= OST_TWO;
      trip_mode_r <= OST_DELAYED;
    end else if (wr && ctrl_hit) begin
      en_r        <= pwdata[`OST_CTRL_EN];
      mode_r      <= ost_steps_t'(pwdata[`OST_CTRL_MODE]);
      trip_mode_r <= ost_trip_t'(pwdata[`OST_CTRL_TRIP]);
    end
  end

  // Timer presets and timers
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tim
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          preset_r[gi] <= PRESET_RST[gi];
        end else if (wr && tim_hit && tim_idx == 3'(gi)) begin
          preset_r[gi] <= pwdata[15:0];
        end
      end

      ost_timer u_tim (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .tick    (tick),
        .run     (t_run[gi]),
        .preset  (preset_r[gi]),
        .done    (t_done[gi])
      );
    end
  endgenerate

  // Read data and error, captured in the setup cycle
  always_comb begin
    rdata_nxt = '0;
    if (ctrl_hit) begin
      rdata_nxt[`OST_CTRL_EN]   = en_r;
      rdata_nxt[`OST_CTRL_MODE] = mode_r;
      rdata_nxt[`OST_CTRL_TRIP] = trip_mode_r;
    end else if (tim_hit) begin
      rdata_nxt[15:0] = preset_r[tim_idx];
    end else if (stat_hit) begin
      rdata_nxt[`OST_ST_LAT1]  = lat1_r;
      rdata_nxt[`OST_ST_LAT2]  = lat2_r;
      rdata_nxt[`OST_ST_LAT3]  = lat3_r;
      rdata_nxt[`OST_ST_LAT4]  = lat4_r;
      rdata_nxt[`OST_ST_BLOCK] = lat1_r;
      rdata_nxt[`OST_ST_TRIP]  = trip_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= pwrite ? '0 : rdata_nxt;
      pslverr <= !(ctrl_hit || tim_hit || stat_hit);
    end
  end

  // Qualified zones
  assign three  = en_r && (mode_r == OST_THREE);
  assign sup    = en_r && overcurrent_supervision;
  assign in_out = sup && zone_outer;
  assign in_mid = sup && zone_middle && three;
  assign in_inn = sup && zone_inner;
  // Two-step times outer to inner, three-step outer to middle
  assign step1  = in_out && (three ? !in_mid : !in_inn);

  // Timer run conditions
  assign t_run[`OST_T_PKP1] = step1 && !lat1_r;
  assign t_run[`OST_T_RST1] = en_r && lat1_r && !in_out;
  assign t_run[`OST_T_PKP2] = three && lat1_r && in_out && in_mid && !in_inn
                              && !lat2_r;
  assign t_run[`OST_T_PKP3] = (three ? lat2_r : lat1_r) && in_out && in_inn
                              && !lat3_r;
  assign t_run[`OST_T_PKP4] = (trip_mode_r == OST_DELAYED) && lat3_r && in_out
                              && !in_inn && !lat4_r;
  assign t_run[`OST_T_SEAL] = trip_r && !trip_set;

  // Latch one, also the block output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat1_r <= 1'b0;
    end else if (clk_en) begin
      if (!en_r) begin
        lat1_r <= 1'b0;
      end else if (t_done[`OST_T_PKP1]) begin
        lat1_r <= 1'b1;
      end else if (t_done[`OST_T_RST1]) begin
        lat1_r <= 1'b0;
      end
    end
  end

  // Latch two, three-step only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat2_r <= 1'b0;
    end else if (clk_en) begin
      if (!three || !in_out) begin
        lat2_r <= 1'b0;
      end else if (t_done[`OST_T_PKP2]) begin
        lat2_r <= 1'b1;
      end
    end
  end

  // Armed latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat3_r <= 1'b0;
    end else if (clk_en) begin
      if (!in_out) begin
        lat3_r <= 1'b0;
      end else if (t_done[`OST_T_PKP3]) begin
        lat3_r <= 1'b1;
      end
    end
  end

  // Delayed trip armed latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat4_r <= 1'b0;
    end else if (clk_en) begin
      if (!en_r || (!in_out && !lat4_r)) begin
        lat4_r <= 1'b0;
      end else if (!in_out) begin
        lat4_r <= 1'b0;
      end else if (t_done[`OST_T_PKP4]) begin
        lat4_r <= 1'b1;
      end
    end
  end

  // Trip pulses
  assign early_pulse = (trip_mode_r == OST_EARLY) && t_done[`OST_T_PKP3];
  assign late_pulse  = en_r && lat4_r && !in_out;
  assign trip_set    = early_pulse || late_pulse;

  // Trip output with seal-in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_r <= 1'b0;
    end else if (clk_en) begin
      if (!en_r || trip_inhibit_input) begin
        trip_r <= 1'b0;
      end else if (trip_set) begin
        trip_r <= 1'b1;
      end else if (t_done[`OST_T_SEAL]) begin
        trip_r <= 1'b0;
      end
    end
  end

  assign block_out = lat1_r;
  assign trip_out  = trip_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_clear: assert property (clk_en && !en_r |=> !block_out && !trip_out && !lat3_r)
    else $error("outputs not cleared while disabled");
  a_l1_set: assert property (clk_en && t_done[`OST_T_PKP1] && en_r |=> block_out)
    else $error("latch one not set on first dwell");
  a_l1_hold: assert property (clk_en && lat1_r && in_out |=> lat1_r)
    else $error("block dropped while inside outer zone");
  a_l2_mode: assert property (clk_en && !three |=> !lat2_r)
    else $error("latch two set in two-step mode");
  a_t2_gate: assert property (t_run[`OST_T_PKP2] |-> three && in_mid)
    else $error("second dwell timer ran outside three-step");
  a_early_trip: assert property (clk_en && early_pulse && !trip_inhibit_input
    |=> trip_out && lat3_r)
    else $error("early trip missing");
  a_late_trip: assert property (clk_en && lat4_r && !in_out && en_r
    && !trip_inhibit_input |=> trip_out && !lat4_r)
    else $error("delayed trip missing on outer exit");
  a_inhibit: assert property (clk_en && trip_inhibit_input |=> !trip_out)
    else $error("trip not cleared by inhibit");
  a_supv_gate: assert property (clk_en && !overcurrent_supervision
    |=> !lat2_r && !lat3_r && !lat4_r)
    else $error("latches held without supervision");
  a_seal_end: assert property (clk_en && trip_r && t_done[`OST_T_SEAL]
    && !trip_set |=> !trip_out)
    else $error("trip not released at seal-in end");

  // Latch set, hold and drop
  a_l2_set: assert property (clk_en && three && in_out
    && t_done[`OST_T_PKP2] |=> lat2_r)
    else $error("latch two not set on second dwell");
  a_l2_hold: assert property (clk_en && three && in_out
    && lat2_r |=> lat2_r)
    else $error("latch two dropped inside outer zone");
  a_l3_set: assert property (clk_en && in_out
    && t_done[`OST_T_PKP3] |=> lat3_r)
    else $error("armed latch not set on third dwell");
  a_l3_hold: assert property (clk_en && in_out
    && lat3_r |=> lat3_r)
    else $error("armed latch dropped inside outer zone");
  a_l4_set: assert property (clk_en && in_out
    && t_done[`OST_T_PKP4] |=> lat4_r)
    else $error("latch four not set on final dwell");
  a_l4_drop: assert property (clk_en && !in_out
    |=> !lat4_r)
    else $error("latch four kept after outer exit");

  // Block reset timing
  a_rst_hold: assert property (clk_en && en_r && lat1_r
    && !t_done[`OST_T_RST1] |=> block_out)
    else $error("block dropped before reset timer expiry");
  a_rst_clear: assert property (clk_en && en_r
    && t_done[`OST_T_RST1] |=> !block_out)
    else $error("block kept after reset timer expiry");

  // First dwell zone selection and seal-in
  a_two_step: assert property (en_r && mode_r == OST_TWO && !lat1_r
    && overcurrent_supervision && zone_outer && !zone_inner
    |-> t_run[`OST_T_PKP1])
    else $error("two-step first dwell not timing");
  a_three_mid: assert property (en_r && mode_r == OST_THREE
    && overcurrent_supervision && zone_middle
    |-> !t_run[`OST_T_PKP1])
    else $error("three-step first dwell ran inside middle zone");
  a_seal_hold: assert property (clk_en && en_r && trip_r
    && !trip_inhibit_input && !t_done[`OST_T_SEAL] |=> trip_out)
    else $error("trip dropped before seal-in end");

  c_block: cover property (!block_out ##1 block_out);
  c_latch2: cover property (clk_en && t_done[`OST_T_PKP2]);
  c_early: cover property (early_pulse ##1 trip_out);
  c_late: cover property (late_pulse ##1 trip_out);
  c_inhibit: cover property (trip_r && trip_inhibit_input ##1 !trip_out);
endmodule

// ---- ost_zone_model.sv ----
module ost_zone_model (
  // Commanded locus depth: 0 outside, 1 outer, 2 middle, 3 inner
  input  wire logic [1:0] depth,
  // Spurious middle flag, driven only in two-step runs, where the sequencer ignores the middle zone
  input  wire logic       noise,
  // Comparator flags
  output logic            zone_outer,
  output logic            zone_middle,
  output logic            zone_inner
);
  timeunit 1ns;
  timeprecision 1ns;
  // Characteristics are nested, so a deeper zone implies the outer ones
  assign zone_outer  = depth != 2'h0;
  assign zone_middle = (depth[1] == 1'b1) | noise;
  assign zone_inner  = depth == 2'h3;
endmodule

// ---- test_out_of_step_trip_sequencer.sv ----
module test_out_of_step_trip_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import ost_pkg::*;
  localparam int CPM = 4;
  logic       pclk = 1'b0;
  logic       presetn = 1'b0;
  logic       clk_en = 1'b1;
  logic       psel = 1'b0;
  logic       penable = 1'b0;
  logic       pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  ost_word_t  pwdata = 32'h0;
  ost_word_t  prdata;
  logic       pready;
  logic       pslverr;
  logic [1:0] depth = 2'h0;
  logic       noise = 1'b0;
  logic       noise_on = 1'b0;
  logic       supv = 1'b0;
  logic       inhibit = 1'b0;
  logic       zo;
  logic       zm;
  logic       zi;
  logic       block_out;
  logic       trip_out;
  int         num_errors = 0;
  int         compares = 0;
  int         seed = 32'hE7B9D9F9;
  int         cycles = 0;
  int         r;
  int         rn;
  int         c1;
  int         c2;
  int         pre_m[6];
  int         small_v[6] = '{2, 3, 2, 2, 2, 6};
  ost_word_t  rst_v[8] = '{32'h0, 32'h1E, 32'h32, 32'h11, 32'h9, 32'h11, 32'h190, 32'h0};
  ost_word_t  q;
  logic       e;

  ost_zone_model zones (.depth(depth), .noise(noise), .zone_outer(zo), .zone_middle(zm),
                        .zone_inner(zi));
  ost_sequencer #(.CYC_PER_MS(CPM)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .zone_outer(zo), .zone_middle(zm), .zone_inner(zi),
    .overcurrent_supervision(supv), .trip_inhibit_input(inhibit),
    .block_out(block_out), .trip_out(trip_out));

  always #20 pclk = ~pclk;

  always @(posedge pclk) begin
    rn = $random(seed);
    noise <= noise_on & rn[0];
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input ost_word_t got, input ost_word_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_win(input int cyc, input int ms);
    compares++;
    if (cyc < (ms - 1) * CPM || cyc > ms * CPM + 8) begin
      num_errors++;
      $display("MISMATCH t=%0t took %0d cycles for %0d ms", $time, cyc, ms);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input ost_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic [1:0] d, input logic s, input logic h);
    @(posedge pclk);
    depth <= d;
    supv <= s;
    inhibit <= h;
  endtask

  task automatic idle(input int ms);
    repeat (ms * CPM) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wait_lvl(input logic trip, input logic lvl, output int cyc);
    cyc = 0;
    @(negedge pclk);
    while ((trip ? trip_out : block_out) !== lvl) begin
      @(negedge pclk);
      cyc++;
    end
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, rst_v[i]);
    end
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h24, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      apb(1'b1, 8'(i * 4 + 4), r);
      apb(1'b0, 8'(i * 4 + 4), 32'h0);
      chk(q, r & 32'hFFFF);
      pre_m[i] = small_v[i];
      apb(1'b1, 8'(i * 4 + 4), pre_m[i]);
    end
    // Disabled element, then enabled element without supervision, ignores a dwelling locus
    go(2'h1, 1'b1, 1'b0);
    idle(pre_m[0] + 3);
    chk(32'(block_out), 32'h0);
    go(2'h0, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    noise_on <= 1'b1;
    go(2'h1, 1'b0, 1'b0);
    idle(pre_m[0] + 2);
    chk(32'(block_out), 32'h0);
    // Two-step delayed swing with a noisy middle flag
    go(2'h1, 1'b1, 1'b0);
    wait_lvl(1'b0, 1'b1, c1);
    chk_win(c1, pre_m[0]);
    go(2'h3, 1'b1, 1'b0);
    idle(pre_m[3] + 2);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h15);
    go(2'h1, 1'b1, 1'b0);
    idle(pre_m[4] + 2);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h1D);
    go(2'h0, 1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1, c1);
    chk(32'(c1 < 3), 32'h1);
    wait_lvl(1'b0, 1'b0, c1);
    chk_win(c1, pre_m[1]);
    wait_lvl(1'b1, 1'b0, c2);
    chk_win(c1 + c2, pre_m[5]);
    // Three-step early swing, inhibit, then disable
    noise_on <= 1'b0;
    apb(1'b1, 8'h00, 32'h7);
    go(2'h1, 1'b1, 1'b0);
    wait_lvl(1'b0, 1'b1, c1);
    chk_win(c1, pre_m[0]);
    go(2'h3, 1'b1, 1'b0);
    idle(pre_m[3] + 2);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h11);
    go(2'h2, 1'b1, 1'b0);
    idle(pre_m[2] + 2);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h13);
    go(2'h3, 1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1, c1);
    chk_win(c1, pre_m[3]);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h37);
    go(2'h3, 1'b1, 1'b1);
    idle(1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h17);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    go(2'h0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
